// *** src/aol_pkg.sv ***
/*
  Constants and types for the analog output level selection block.
  Assumes a 250 MHz clock and a 32-bit APB register bus.
*/
package aol_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] AOL_OFS_CTRL = 8'h00;
  localparam logic [7:0] AOL_OFS_VOLT = 8'h04;
  localparam logic [7:0] AOL_OFS_CURR = 8'h08;
  localparam logic [7:0] AOL_OFS_NT_DLY = 8'h0C;
  localparam logic [7:0] AOL_OFS_NS_DLY = 8'h10;
  localparam logic [7:0] AOL_OFS_TEACH = 8'h14;
  localparam logic [7:0] AOL_OFS_STATUS = 8'h18;
  localparam logic [7:0] AOL_OFS_OUT = 8'h1C;

  // ==========================================================
  // Control field positions
  localparam int AOL_CTRL_PU_V = 0;
  localparam int AOL_CTRL_PU_I = 1;
  localparam int AOL_CTRL_NT_V = 2;
  localparam int AOL_CTRL_NT_I = 4;
  localparam int AOL_CTRL_NS_V = 6;
  localparam int AOL_CTRL_NS_I = 8;
  localparam int AOL_CTRL_SLAVE = 10;
  localparam int AOL_CTRL_W = 11;
  localparam logic [10:0] AOL_CTRL_RST = 11'h2A8;

  // Status field positions
  localparam int AOL_ST_VREJ = 0;
  localparam int AOL_ST_IREJ = 1;
  localparam int AOL_ST_TREJ = 2;
  localparam int AOL_ST_NT = 3;
  localparam int AOL_ST_NS = 4;
  localparam int AOL_ST_RUN = 5;
  localparam int AOL_ST_SYNC = 6;

  // ==========================================================
  // Levels: voltage in mV, current in uA
  localparam logic [15:0] AOL_VH_MIN = 16'h0064;
  localparam logic [15:0] AOL_VH_MAX = 16'h2710;
  localparam logic [15:0] AOL_VH_RST = 16'h2710;
  localparam logic [15:0] AOL_VL_MIN = 16'h0000;
  localparam logic [15:0] AOL_VL_MAX = 16'h26AC;
  localparam logic [15:0] AOL_VL_RST = 16'h0000;
  localparam logic [15:0] AOL_V_STEP = 16'h0032;
  localparam logic [15:0] AOL_V_SEP = 16'h03E8;
  localparam logic [15:0] AOL_IH_MIN = 16'h0898;
  localparam logic [15:0] AOL_IH_MAX = 16'h4E20;
  localparam logic [15:0] AOL_IH_RST = 16'h4E20;
  localparam logic [15:0] AOL_IL_MIN = 16'h07D0;
  localparam logic [15:0] AOL_IL_MAX = 16'h4DBC;
  localparam logic [15:0] AOL_IL_RST = 16'h0FA0;
  localparam logic [15:0] AOL_I_STEP = 16'h0064;
  localparam logic [15:0] AOL_I_SEP = 16'h07D0;

  // Teach commands and the levels they load
  localparam logic [7:0] AOL_TEACH_5V = 8'h1E;
  localparam logic [7:0] AOL_TEACH_10V = 8'h1F;
  localparam logic [15:0] AOL_TEACH_VH5 = 16'h1388;
  localparam logic [15:0] AOL_TEACH_VH10 = 16'h2710;
  localparam logic [15:0] AOL_TEACH_VL = 16'h0000;

  // ==========================================================
  // Delay timing: 5 ms tick, 4 ns clock
  localparam int AOL_TICK_MS = 5;
  localparam int AOL_CLK_PERIOD_NS = 4;
  localparam int AOL_TICK_CYCLES = AOL_TICK_MS * 1000000 / AOL_CLK_PERIOD_NS;
  localparam logic [15:0] AOL_DLY_RST = 16'h0000;

  // Fallback choices
  typedef enum logic [1:0] {
    AOL_FB_LOW = 2'b00,
    AOL_FB_HIGH = 2'b01,
    AOL_FB_HOLD = 2'b10
  } aol_fb_t;

  // Output phase
  typedef enum logic [1:0] {
    AOL_PH_POWERUP = 2'b01,
    AOL_PH_RUN = 2'b10
  } aol_phase_t;

endpackage

// *** src/aol_delay_timer.sv ***
/*
  Absence timer: counts 5 ms ticks while a condition holds without break.
  Assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module aol_delay_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timing
  input wire logic tick,
  input wire logic cond,
  input wire logic [15:0] delay,
  // Result
  output logic expired
);
  import aol_pkg::*;

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_expired;

  // ==========================================================
  // Count resets whenever the condition breaks
  always_comb begin
    next_count = count;
    if (!cond) begin
      next_count = 16'h0000;
    end else if (tick && (count != 16'hFFFF)) begin
      next_count = count + 16'h0001;
    end
    next_expired = cond && (next_count >= delay);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end

endmodule // aol_delay_timer

// *** src/aol_level_select.sv ***
/*
  Analog output level selection: holds and checks the voltage and current
  levels, picks power-up and fallback levels, scales the outputs.
  Assumes the measurement engine on the same clock gives a done pulse,
  target flag and window position; the sync pin is asynchronous.
*/
// The implementer's own choices: the APB register port and the register addresses.
// Summary of operation
// [RULE1] Voltage high 0.1 to 10 V, 50 mV
// [RULE2] Voltage high at least 1 V above low
// [RULE3] Voltage low 0 to 9.9 V, 50 mV
// [RULE4] Teach 30/31 load 5/10 V, low 0 V
// [RULE5] Current high 2.2 to 20 mA, 0.1 mA
// [RULE6] Current high at least 2 mA above low
// [RULE7] Current low 2 to 19.9 mA, default 4
// [RULE8] Beyond endpoints drive high or low level
// [RULE9] Voltage power-up level until first measurement; code holds it until the second measurement or a fallback
// [RULE10] Current power-up level until first measurement; code holds it until the second measurement or a fallback
// [RULE11] Voltage no-target fallback: low, high, hold
// [RULE12] Current no-target fallback: low, high, hold
// [RULE13] One shared continuous no-target delay, 5 ms
// [RULE14] Sync slave lost master: voltage fallback
// [RULE15] Sync slave lost master: current fallback
// [RULE16] One shared no-sync delay, default 0
// [RULE17] Linear scaling between endpoints
// [RULE18] Both outputs share one slope direction
// [RULE19] Resume scaled output on next measurement
// [RULE20] Bad level writes rejected, old kept
`timescale 1ns/1ps
module aol_level_select #(
  parameter int TICK_CYCLES = aol_pkg::AOL_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement engine
  input wire logic meas_done,
  input wire logic target_seen,
  input wire logic at_high_end,
  input wire logic at_low_end,
  input wire logic [15:0] window_pos,
  // Sync link
  input wire logic master_sync_pin,
  // Converter codes
  output logic [15:0] volt_code,
  output logic [15:0] curr_code
);
  import aol_pkg::*;

  // ==========================================================
  // State
  logic [AOL_CTRL_W-1:0] ctrl, next_ctrl;
  logic [15:0] vh, vl, ih, il, next_vh, next_vl, next_ih, next_il;
  logic [15:0] nt_dly, ns_dly, next_nt_dly, next_ns_dly;
  logic [2:0] rej, next_rej;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [15:0] next_volt_code, next_curr_code;
  aol_phase_t phase, next_phase;
  logic sync_ff1, sync_ff2;
  logic [20:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic nt_exp, ns_exp;
  logic wr_en, mapped;
  logic [15:0] wr_hi, wr_lo;
  logic v_ok, i_ok;
  logic [31:0] v_scaled, i_scaled;

  assign wr_en = psel && penable && pready && pwrite;
  assign wr_hi = pwdata[31:16];
  assign wr_lo = pwdata[15:0];

  // ==========================================================
  // Level checks
  always_comb begin
    v_ok = (wr_hi >= AOL_VH_MIN) && (wr_hi <= AOL_VH_MAX)
        && ((wr_hi % AOL_V_STEP) == 16'h0000); // [RULE1]
    v_ok = v_ok && (wr_lo >= AOL_VL_MIN) && (wr_lo <= AOL_VL_MAX)
        && ((wr_lo % AOL_V_STEP) == 16'h0000); // [RULE3]
    v_ok = v_ok && (wr_hi >= wr_lo) && ((wr_hi - wr_lo) >= AOL_V_SEP); // [RULE2]
    i_ok = (wr_hi >= AOL_IH_MIN) && (wr_hi <= AOL_IH_MAX)
        && ((wr_hi % AOL_I_STEP) == 16'h0000); // [RULE5]
    i_ok = i_ok && (wr_lo >= AOL_IL_MIN) && (wr_lo <= AOL_IL_MAX)
        && ((wr_lo % AOL_I_STEP) == 16'h0000); // [RULE7]
    i_ok = i_ok && (wr_hi >= wr_lo) && ((wr_hi - wr_lo) >= AOL_I_SEP); // [RULE6]
  end

  // ==========================================================
  // Register file and APB
  always_comb begin
    mapped = 1'b1;
    next_ctrl = ctrl;
    next_vh = vh;
    next_vl = vl;
    next_ih = ih;
    next_il = il;
    next_nt_dly = nt_dly;
    next_ns_dly = ns_dly;
    next_rej = rej;
    next_prdata = 32'h0000_0000;
    case (paddr)
      AOL_OFS_CTRL: next_prdata = {21'h000000, ctrl};
      AOL_OFS_VOLT: next_prdata = {vh, vl};
      AOL_OFS_CURR: next_prdata = {ih, il};
      AOL_OFS_NT_DLY: next_prdata = {16'h0000, nt_dly};
      AOL_OFS_NS_DLY: next_prdata = {16'h0000, ns_dly};
      AOL_OFS_TEACH: next_prdata = 32'h0000_0000;
      AOL_OFS_STATUS: begin
        next_prdata = 32'h0000_0000;
        next_prdata[AOL_ST_VREJ] = rej[0];
        next_prdata[AOL_ST_IREJ] = rej[1];
        next_prdata[AOL_ST_TREJ] = rej[2];
        next_prdata[AOL_ST_NT] = nt_exp;
        next_prdata[AOL_ST_NS] = ns_exp;
        next_prdata[AOL_ST_RUN] = (phase == AOL_PH_RUN);
        next_prdata[AOL_ST_SYNC] = sync_ff2;
      end
      AOL_OFS_OUT: next_prdata = {curr_code, volt_code};
      default: mapped = 1'b0;
    endcase
    if (wr_en) begin
      case (paddr)
        AOL_OFS_CTRL: next_ctrl = pwdata[AOL_CTRL_W-1:0];
        AOL_OFS_VOLT: begin
          if (v_ok) begin
            next_vh = wr_hi;
            next_vl = wr_lo;
          end
        end
        AOL_OFS_CURR: begin
          if (i_ok) begin
            next_ih = wr_hi;
            next_il = wr_lo;
          end
        end
        AOL_OFS_NT_DLY: next_nt_dly = wr_lo; // [RULE13]
        AOL_OFS_NS_DLY: next_ns_dly = wr_lo; // [RULE16]
        AOL_OFS_TEACH: begin
          if (pwdata[7:0] == AOL_TEACH_5V) begin
            next_vh = AOL_TEACH_VH5; // [RULE4]
            next_vl = AOL_TEACH_VL; // [RULE4]
          end else if (pwdata[7:0] == AOL_TEACH_10V) begin
            next_vh = AOL_TEACH_VH10; // [RULE4]
            next_vl = AOL_TEACH_VL; // [RULE4]
          end
        end
        AOL_OFS_STATUS: next_rej = rej & ~pwdata[2:0];
        default: next_rej = rej;
      endcase
    end
    // Reject flags set after clear so a new reject wins
    if (wr_en && (paddr == AOL_OFS_VOLT) && !v_ok) begin
      next_rej[0] = 1'b1; // [RULE20]
    end
    if (wr_en && (paddr == AOL_OFS_CURR) && !i_ok) begin
      next_rej[1] = 1'b1; // [RULE20]
    end
    if (wr_en && (paddr == AOL_OFS_TEACH) && (pwdata[7:0] != AOL_TEACH_5V)
        && (pwdata[7:0] != AOL_TEACH_10V)) begin
      next_rej[2] = 1'b1;
    end
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    if (!next_pready) begin
      next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= AOL_CTRL_RST;
      vh <= AOL_VH_RST;
      vl <= AOL_VL_RST;
      ih <= AOL_IH_RST;
      il <= AOL_IL_RST;
      nt_dly <= AOL_DLY_RST;
      ns_dly <= AOL_DLY_RST;
      rej <= 3'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      vh <= next_vh;
      vl <= next_vl;
      ih <= next_ih;
      il <= next_il;
      nt_dly <= next_nt_dly;
      ns_dly <= next_ns_dly;
      rej <= next_rej;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Sync pin and 5 ms tick
  always_comb begin
    next_tick = (tick_cnt == 21'(TICK_CYCLES - 1));
    next_tick_cnt = next_tick ? 21'h000000 : tick_cnt + 21'h000001;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
      tick_cnt <= 21'h000000;
      tick <= 1'b0;
    end else begin
      sync_ff1 <= master_sync_pin;
      sync_ff2 <= sync_ff1;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // One timer per condition, each shared by both outputs
  aol_delay_timer u_nt_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .cond(!target_seen), // [RULE13]
    .delay(nt_dly),
    .expired(nt_exp)
  );

  aol_delay_timer u_ns_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .cond(ctrl[AOL_CTRL_SLAVE] && !sync_ff2), // [RULE16]
    .delay(ns_dly),
    .expired(ns_exp)
  );

  // ==========================================================
  // Level selection
  function automatic logic [15:0] aol_pick(input logic [1:0] mode,
      input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] cur);
    case (mode)
      AOL_FB_LOW: aol_pick = lo;
      AOL_FB_HIGH: aol_pick = hi;
      default: aol_pick = cur;
    endcase
  endfunction

  // One window position drives both, so slopes always agree
  assign v_scaled = 32'(vh - vl) * 32'(window_pos); // [RULE17] [RULE18]
  assign i_scaled = 32'(ih - il) * 32'(window_pos); // [RULE17] [RULE18]

  always_comb begin
    next_phase = phase;
    next_volt_code = volt_code;
    next_curr_code = curr_code;
    case (phase)
      AOL_PH_POWERUP: begin
        next_volt_code = ctrl[AOL_CTRL_PU_V] ? vh : vl; // [RULE9]
        next_curr_code = ctrl[AOL_CTRL_PU_I] ? ih : il; // [RULE10]
        if (meas_done) begin
          next_phase = AOL_PH_RUN;
        end
      end
      AOL_PH_RUN: begin
        if (ns_exp) begin
          next_volt_code = aol_pick(ctrl[AOL_CTRL_NS_V +: 2], vl, vh, volt_code); // [RULE14]
          next_curr_code = aol_pick(ctrl[AOL_CTRL_NS_I +: 2], il, ih, curr_code); // [RULE15]
        end else if (nt_exp) begin
          next_volt_code = aol_pick(ctrl[AOL_CTRL_NT_V +: 2], vl, vh, volt_code); // [RULE11]
          next_curr_code = aol_pick(ctrl[AOL_CTRL_NT_I +: 2], il, ih, curr_code); // [RULE12]
        end else if (meas_done && target_seen) begin
          // Fallback left only on a completed measurement
          if (at_high_end) begin
            next_volt_code = vh; // [RULE8] [RULE19]
            next_curr_code = ih; // [RULE8] [RULE19]
          end else if (at_low_end) begin
            next_volt_code = vl; // [RULE8] [RULE19]
            next_curr_code = il; // [RULE8] [RULE19]
          end else begin
            next_volt_code = vl + v_scaled[31:16]; // [RULE17] [RULE19]
            next_curr_code = il + i_scaled[31:16]; // [RULE17] [RULE19]
          end
        end
      end
      default: next_phase = AOL_PH_POWERUP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= AOL_PH_POWERUP;
      volt_code <= AOL_VL_RST;
      curr_code <= AOL_IL_RST;
    end else begin
      phase <= next_phase;
      volt_code <= next_volt_code;
      curr_code <= next_curr_code;
    end
  end

endmodule // aol_level_select

// *** tb/aol_conv_model.sv ***
/*
  Output converter stage model: takes the level codes and settles one clock later.
  Assumes codes from aol_level_select on the same clock.
*/
`timescale 1ns/1ps
module aol_conv_model (
  // Clock
  input wire logic clk,
  // Codes in
  input wire logic [15:0] volt_code,
  input wire logic [15:0] curr_code,
  // Settled levels
  output logic [15:0] volt_mv,
  output logic [15:0] curr_ua
);
  always_ff @(posedge clk) begin
    volt_mv <= volt_code;
    curr_ua <= curr_code;
  end
endmodule // aol_conv_model

// *** tb/aol_level_select_properties.sv ***
/*
  Port checker for aol_level_select.
  Assumes the design's port names; bound to every instance.
*/
`timescale 1ns/1ps
module aol_level_select_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Codes
  input wire logic [15:0] volt_code,
  input wire logic [15:0] curr_code
);
  import aol_pkg::*;
  // ==========
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  reset_level_a: assert property (
    disable iff (1'b0) rst |=> volt_code == AOL_VL_RST && curr_code == AOL_IL_RST)
    else $error("codes not at reset level");
  volt_range_a: assert property (volt_code <= AOL_VH_MAX)
    else $error("voltage code out of range");
  curr_range_a: assert property (
    curr_code >= AOL_IL_MIN && curr_code <= AOL_IH_MAX)
    else $error("current code out of range");
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer to access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (
    psel && penable && !pready && paddr > AOL_OFS_OUT |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    psel && penable && !pready && paddr <= AOL_OFS_OUT && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  idle_read_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
endmodule // aol_level_select_properties

bind aol_level_select aol_level_select_properties chk_u (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .volt_code(volt_code), .curr_code(curr_code));

// *** tb/aol_level_select_tb.sv ***
/*
  Self-checking bench for aol_level_select with a converter model.
  Assumes aol_pkg and the design compiled first; tick shortened to 10 cycles.
*/
`timescale 1ns/1ps
module aol_level_select_tb;
  import aol_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, meas_done = 0;
  logic target_seen = 1, at_high_end = 0, at_low_end = 0, master_sync_pin = 1;
  logic pready, pslverr;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] window_pos = 16'h0, volt_code, curr_code, vm, im;
  logic e;
  int fails = 0, checks_done = 0;
  logic [10:0] tok = 11'h431, isc = 11'h7E0;
  logic [31:0] td [0:10] = '{32'h03E8_0000, 32'h03B6_0000, 32'h1789_03E8, 32'h2742_0000,
    32'h1F40_07D0, 32'h1770_0FA0, 32'h170C_0FA0, 32'h4E84_0FA0, 32'h17A2_0FA0,
    32'h1770_076C, 32'h3E80_1770};

  always #2 clk = ~clk;

  aol_level_select #(.TICK_CYCLES(10)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_done(meas_done), .target_seen(target_seen),
    .at_high_end(at_high_end), .at_low_end(at_low_end), .window_pos(window_pos),
    .master_sync_pin(master_sync_pin), .volt_code(volt_code), .curr_code(curr_code));
  aol_conv_model conv_u (.clk(clk), .volt_code(volt_code), .curr_code(curr_code),
    .volt_mv(vm), .curr_ua(im));

  // ==========
  // Shared tasks
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle between transfers
    @(posedge clk);
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic meas(input logic [15:0] p, input logic h, input logic l);
    meas_done <= 1'b1;
    window_pos <= p;
    at_high_end <= h;
    at_low_end <= l;
    @(posedge clk);
    meas_done <= 1'b0;
    at_high_end <= 1'b0;
    at_low_end <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic poll(input logic [15:0] v, input logic [15:0] i);
    int n;
    n = 0;
    while ((vm !== v || im !== i) && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("volt", {16'h0, v}, {16'h0, vm});
    chk("curr", {16'h0, i}, {16'h0, im});
    if (n >= 100)
      complete_run();
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    apb(1'b0, AOL_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h2A8, r);
    apb(1'b0, AOL_OFS_VOLT, 32'h0);
    chk("volt lv", 32'h2710_0000, r);
    apb(1'b0, AOL_OFS_CURR, 32'h0);
    chk("curr lv", 32'h4E20_0FA0, r);
    apb(1'b0, AOL_OFS_NT_DLY, 32'h0);
    chk("nt dly", 32'h0, r);
    apb(1'b0, AOL_OFS_OUT, 32'h0);
    chk("out", 32'h0FA0_0000, r);
  endtask

  task automatic t_powerup;
    apb(1'b1, AOL_OFS_CTRL, 32'h2AB);
    poll(16'h2710, 16'h4E20);
    // First completed measurement only ends the power-up phase
    meas(16'h8000, 1'b0, 1'b0);
    poll(16'h2710, 16'h4E20);
    meas(16'h8000, 1'b0, 1'b0);
    poll(16'h1388, 16'h2EE0);
    meas(16'h8000, 1'b1, 1'b0);
    poll(16'h2710, 16'h4E20);
    meas(16'h8000, 1'b0, 1'b1);
    poll(16'h0000, 16'h0FA0);
    apb(1'b1, AOL_OFS_CTRL, 32'h2A8);
  endtask

  task automatic t_teach;
    apb(1'b1, AOL_OFS_TEACH, 32'h1E);
    apb(1'b0, AOL_OFS_VOLT, 32'h0);
    chk("teach 5v", 32'h1388_0000, r);
    apb(1'b1, AOL_OFS_TEACH, 32'h1F);
    apb(1'b0, AOL_OFS_VOLT, 32'h0);
    chk("teach 10v", 32'h2710_0000, r);
    apb(1'b1, AOL_OFS_STATUS, 32'h7);
    apb(1'b1, AOL_OFS_TEACH, 32'h1D);
    apb(1'b0, AOL_OFS_STATUS, 32'h0);
    chk("teach rej", 32'h4, r & 32'h7);
  endtask

  task automatic t_levels;
    logic [31:0] lv, li;
    lv = 32'h2710_0000;
    li = 32'h4E20_0FA0;
    for (int k = 0; k < 11; k++) begin
      apb(1'b1, AOL_OFS_STATUS, 32'h7);
      apb(1'b1, isc[k] ? AOL_OFS_CURR : AOL_OFS_VOLT, td[k]);
      if (tok[k] && isc[k])
        li = td[k];
      if (tok[k] && !isc[k])
        lv = td[k];
      apb(1'b0, isc[k] ? AOL_OFS_CURR : AOL_OFS_VOLT, 32'h0);
      chk("level", isc[k] ? li : lv, r);
      apb(1'b0, AOL_OFS_STATUS, 32'h0);
      chk("reject", {31'h0, !tok[k]}, {31'h0, r[isc[k]]});
    end
  endtask

  task automatic t_notarget;
    apb(1'b1, AOL_OFS_CTRL, 32'h290);
    apb(1'b1, AOL_OFS_NT_DLY, 32'h2);
    meas(16'h8000, 1'b0, 1'b0);
    poll(16'h1388, 16'h2AF8);
    target_seen <= 1'b0;
    repeat (9) @(posedge clk);
    target_seen <= 1'b1;
    @(posedge clk);
    target_seen <= 1'b0;
    repeat (9) @(posedge clk);
    poll(16'h1388, 16'h2AF8);
    poll(16'h07D0, 16'h3E80);
    meas(16'h4000, 1'b0, 1'b0);
    poll(16'h07D0, 16'h3E80);
    target_seen <= 1'b1;
    repeat (3) @(posedge clk);
    meas(16'h4000, 1'b0, 1'b0);
    poll(16'h0DAC, 16'h2134);
  endtask

  task automatic t_nosync;
    apb(1'b1, AOL_OFS_CTRL, 32'h468);
    apb(1'b1, AOL_OFS_NS_DLY, 32'h3);
    apb(1'b0, AOL_OFS_NS_DLY, 32'h0);
    chk("ns dly", 32'h3, r);
    master_sync_pin <= 1'b0;
    poll(16'h1F40, 16'h1770);
    master_sync_pin <= 1'b1;
    repeat (5) @(posedge clk);
    meas(16'h8000, 1'b0, 1'b0);
    poll(16'h1388, 16'h2AF8);
  endtask

  task automatic t_unmapped;
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    chk("wr err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h20, 32'h0);
    chk("rd err", 32'h1, {31'h0, e});
    chk("rd data", 32'h0, r);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_powerup();
    t_teach();
    t_levels();
    t_notarget();
    t_nosync();
    t_unmapped();
    complete_run();
  end
endmodule // aol_level_select_tb
